// [mbag_pkg.sv]
// Shared constants and types of the modulo and bit-reversed address generator.
package mbag_pkg;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam logic [7:0]  ADR_BITREV_CTRL = 8'h00;
    localparam logic [7:0]  ADR_CIRC_CTRL   = 8'h04;
    localparam logic [7:0]  ADR_MOD_START   = 8'h08;
    localparam logic [7:0]  ADR_MOD_END     = 8'h0C;
    localparam logic [7:0]  ADR_STATUS      = 8'h10;

    // ==========================================================================
    // Field positions and reset values
    // ==========================================================================
    localparam int unsigned BREV_EN_BIT     = 15;
    localparam int unsigned BREV_MOD_MSB    = 14;
    localparam int unsigned CIRC_EN_BIT     = 15;
    localparam int unsigned BREV_SEL_LSB    = 8;
    localparam int unsigned MOD_SEL_LSB     = 0;
    localparam logic [15:0] BITREV_RST      = 16'h0000;
    localparam logic [15:0] CIRC_RST        = 16'h0000;
    localparam logic [15:0] MOD_START_RST   = 16'h0000;
    localparam logic [15:0] MOD_END_RST     = 16'h0000;
    localparam logic [3:0]  STACK_PTR_SEL   = 4'hF;
    localparam logic [15:0] STEP_BYTE       = 16'h0001;
    localparam logic [15:0] STEP_WORD       = 16'h0002;

    // ==========================================================================
    // Addressing modes supplied by instruction decode
    // ==========================================================================
    typedef enum logic [2:0]
    {
        MODE_INDIRECT = 3'b000,
        MODE_POST_INC = 3'b001,
        MODE_POST_DEC = 3'b010,
        MODE_PRE_INC  = 3'b011,
        MODE_PRE_DEC  = 3'b100,
        MODE_OFFSET   = 3'b101
    } mbag_mode_e;

endpackage : mbag_pkg

// [mbag_bitrev_add.sv]
// Reverse-carry adder that steps a word pointer by a bit-reversed modifier.
`timescale 1ns/1ps
`default_nettype none
module mbag_bitrev_add
(
    // Operands.
    input  wire logic [14:0] ptr_idx_i,
    input  wire logic [14:0] mod_i,
    // Result.
    output logic      [14:0] sum_o
);
    logic [14:0] ptr_rev;
    logic [14:0] mod_rev;
    logic [14:0] sum_rev;

    // ==========================================================================
    // Bit reversal
    // ==========================================================================
    // Carries travel from high to low bits, so an aligned buffer wraps cleanly.
    genvar g;
    generate
        for (g = 0; g < 15; g++)
        begin : g_rev
            assign ptr_rev[g] = ptr_idx_i[14 - g];
            assign mod_rev[g] = mod_i[14 - g];
            assign sum_o[g]   = sum_rev[14 - g];
        end
    endgenerate

    assign sum_rev = 15'(ptr_rev + mod_rev);
endmodule : mbag_bitrev_add
`default_nettype wire

// [mbag_modulo_fix.sv]
// Circular buffer boundary correction of one address.
`timescale 1ns/1ps
`default_nettype none
module mbag_modulo_fix
(
    // Buffer description.
    input  wire logic        enable_i,
    input  wire logic        up_i,
    input  wire logic [15:0] start_i,
    input  wire logic [15:0] end_i,
    // Address in and out.
    input  wire logic [15:0] addr_i,
    output logic      [15:0] addr_o,
    output logic             wrapped_o
);
    logic [15:0] len;

    // ==========================================================================
    // Correction
    // ==========================================================================
    // Beyond-boundary compares catch steps that jump past the boundary.
    always_comb
    begin
        len       = 16'(end_i - start_i + 16'h0001);
        addr_o    = addr_i;
        wrapped_o = 1'b0;
        if (enable_i && up_i && (addr_i > end_i))
        begin
            addr_o    = 16'(addr_i - len);
            wrapped_o = 1'b1;
        end
        else if (enable_i && !up_i && (addr_i < start_i))
        begin
            addr_o    = 16'(addr_i + len);
            wrapped_o = 1'b1;
        end
    end
endmodule : mbag_modulo_fix
`default_nettype wire

// [mbag_addr_gen.sv]
// Effective address generator with modulo and bit-reversed addressing.
// Function
// - Modulo correction usable with any pointer register.
// - Compare upper or lower boundary, including overshoot.
// - Write corrected pointer back only for pre/post modify.
// - Offset mode corrects address, pointer stays unchanged.
// - Bit reversal only X unit, only writes.
// - Pointer and modifier are both bit-reversed.
// - Enable needs select not 1111, enable, increment mode.
// - Modifier bits 14:0, enable bit 15.
// - Bit-reversed addresses are word sized, LSB clear.
// - Byte or other modes give normal addresses.
// - Pointer plus reversed modifier, increment ignored, LSB zero.
// - Bit reversal wins over modulo on writes.
`timescale 1ns/1ps
`default_nettype none
module mbag_addr_gen
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone register slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Address request from instruction execute.
    input  wire logic        req_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic [3:0]  ptr_sel_i,
    input  wire logic [15:0] ptr_val_i,
    input  wire logic [15:0] offset_i,
    input  wire logic        byte_i,
    input  wire logic        write_i,
    input  wire logic        x_unit_i,
    // Generated address and pointer write-back.
    output logic             ea_valid_o,
    output logic      [15:0] ea_o,
    output logic             ea_brev_o,
    output logic             ptr_wb_en_o,
    output logic      [3:0]  ptr_wb_sel_o,
    output logic      [15:0] ptr_wb_val_o
);
    // ==========================================================================
    // Register state
    // ==========================================================================
    logic [15:0] bitrev_reg,    bitrev_next;
    logic [15:0] circ_reg,      circ_next;
    logic [15:0] mstart_reg,    mstart_next;
    logic [15:0] mend_reg,      mend_next;
    logic        ack_reg,       ack_next;
    logic [31:0] rdat_reg,      rdat_next;
    logic        access;
    logic        wr_take;

    always_comb
    begin
        access      = wb_cyc_i && wb_stb_i;
        wr_take     = access && wb_we_i && ack_reg;
        ack_next    = access && !ack_reg;
        rdat_next   = rdat_reg;
        bitrev_next = bitrev_reg;
        circ_next   = circ_reg;
        mstart_next = mstart_reg;
        mend_next   = mend_reg;
        if (access && !ack_reg)
        begin
            unique case (wb_adr_i)
                mbag_pkg::ADR_BITREV_CTRL: rdat_next = {16'h0000, bitrev_reg};
                mbag_pkg::ADR_CIRC_CTRL:   rdat_next = {16'h0000, circ_reg};
                mbag_pkg::ADR_MOD_START:   rdat_next = {16'h0000, mstart_reg};
                mbag_pkg::ADR_MOD_END:     rdat_next = {16'h0000, mend_reg};
                mbag_pkg::ADR_STATUS:      rdat_next = {14'h0000, ea_brev_o,
                                                        ptr_wb_en_o, ea_o};
                default:                   rdat_next = 32'h00000000;
            endcase
        end
        if (wr_take)
        begin
            unique case (wb_adr_i)
                mbag_pkg::ADR_BITREV_CTRL:
                begin
                    if (wb_sel_i[0]) bitrev_next[7:0]  = wb_dat_i[7:0];
                    if (wb_sel_i[1]) bitrev_next[15:8] = wb_dat_i[15:8];
                end
                mbag_pkg::ADR_CIRC_CTRL:
                begin
                    if (wb_sel_i[0]) circ_next[3:0]  = wb_dat_i[3:0];
                    if (wb_sel_i[1])
                    begin
                        circ_next[11:8] = wb_dat_i[11:8];
                        circ_next[15]   = wb_dat_i[15];
                    end
                end
                mbag_pkg::ADR_MOD_START:
                begin
                    if (wb_sel_i[0]) mstart_next[7:0]  = wb_dat_i[7:0];
                    if (wb_sel_i[1]) mstart_next[15:8] = wb_dat_i[15:8];
                end
                mbag_pkg::ADR_MOD_END:
                begin
                    if (wb_sel_i[0]) mend_next[7:0]  = wb_dat_i[7:0];
                    if (wb_sel_i[1]) mend_next[15:8] = wb_dat_i[15:8];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bitrev_reg <= mbag_pkg::BITREV_RST;
            circ_reg   <= mbag_pkg::CIRC_RST;
            mstart_reg <= mbag_pkg::MOD_START_RST;
            mend_reg   <= mbag_pkg::MOD_END_RST;
            ack_reg    <= 1'b0;
            rdat_reg   <= 32'h00000000;
        end
        else
        begin
            bitrev_reg <= bitrev_next;
            circ_reg   <= circ_next;
            mstart_reg <= mstart_next;
            mend_reg   <= mend_next;
            ack_reg    <= ack_next;
            rdat_reg   <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ==========================================================================
    // Control decode
    // ==========================================================================
    logic        brev_en;
    logic [14:0] brev_mod;
    logic        circ_en;
    logic [3:0]  brev_sel;
    logic [3:0]  mod_sel;
    logic        is_inc;
    logic        is_dec;
    logic        is_pre;
    logic        is_modify;
    logic        mod_hit;
    logic        brev_act;
    logic [15:0] step;
    logic [15:0] step_val;
    logic        step_up;
    logic [15:0] fixed_val;
    logic [14:0] brev_sum;
    logic [15:0] brev_ea;
    logic [15:0] mod_len;

    always_comb
    begin
        brev_en   = bitrev_reg[mbag_pkg::BREV_EN_BIT];
        brev_mod  = bitrev_reg[mbag_pkg::BREV_MOD_MSB:0];
        circ_en   = circ_reg[mbag_pkg::CIRC_EN_BIT];
        brev_sel  = circ_reg[mbag_pkg::BREV_SEL_LSB +: 4];
        mod_sel   = circ_reg[mbag_pkg::MOD_SEL_LSB +: 4];
        is_inc    = (mode_i == mbag_pkg::MODE_POST_INC) || (mode_i == mbag_pkg::MODE_PRE_INC);
        is_dec    = (mode_i == mbag_pkg::MODE_POST_DEC) || (mode_i == mbag_pkg::MODE_PRE_DEC);
        is_pre    = (mode_i == mbag_pkg::MODE_PRE_INC) || (mode_i == mbag_pkg::MODE_PRE_DEC);
        is_modify = is_inc || is_dec;
        mod_hit   = circ_en && (ptr_sel_i == mod_sel);
        mod_len   = 16'(mend_reg - mstart_reg + 16'h0001);
        brev_act  = brev_en && (brev_sel != mbag_pkg::STACK_PTR_SEL)
                    && (ptr_sel_i == brev_sel) && is_inc
                    && x_unit_i && write_i && !byte_i;
        step      = byte_i ? mbag_pkg::STEP_BYTE : mbag_pkg::STEP_WORD;
        step_up   = 1'b1;
        step_val  = ptr_val_i;
        unique case (mode_i)
            mbag_pkg::MODE_POST_INC, mbag_pkg::MODE_PRE_INC:
                step_val = 16'(ptr_val_i + step);
            mbag_pkg::MODE_POST_DEC, mbag_pkg::MODE_PRE_DEC:
            begin
                step_val = 16'(ptr_val_i - step);
                step_up  = 1'b0;
            end
            mbag_pkg::MODE_OFFSET:
            begin
                step_val = 16'(ptr_val_i + offset_i);
                step_up  = !offset_i[15];
            end
            default:
                step_val = ptr_val_i;
        endcase
        brev_ea   = {brev_sum, 1'b0};
    end

    // ==========================================================================
    // Datapath units
    // ==========================================================================
    // Both the pointer index and the modifier are reversed inside the adder; the sum is reversed back.
    mbag_bitrev_add u_brev
    (
        .ptr_idx_i (ptr_val_i[15:1]),
        .mod_i     (brev_mod),
        .sum_o     (brev_sum)
    );

    mbag_modulo_fix u_mod
    (
        .enable_i  (mod_hit && (mode_i != mbag_pkg::MODE_INDIRECT)),
        .up_i      (step_up),
        .start_i   (mstart_reg),
        .end_i     (mend_reg),
        .addr_i    (step_val),
        .addr_o    (fixed_val),
        .wrapped_o ()
    );

    // ==========================================================================
    // Result registers
    // ==========================================================================
    logic        valid_reg,  valid_next;
    logic [15:0] ea_reg,     ea_next;
    logic        brev_reg,   brev_next;
    logic        wben_reg,   wben_next;
    logic [3:0]  wbsel_reg,  wbsel_next;
    logic [15:0] wbval_reg,  wbval_next;

    always_comb
    begin
        valid_next = req_i;
        ea_next    = ea_reg;
        brev_next  = brev_reg;
        wben_next  = 1'b0;
        wbsel_next = wbsel_reg;
        wbval_next = wbval_reg;
        if (req_i)
        begin
            wbsel_next = ptr_sel_i;
            brev_next  = brev_act;
            if (brev_act)
            begin
                // Step size is ignored and modulo is bypassed here.
                ea_next    = is_pre ? brev_ea : {ptr_val_i[15:1], 1'b0};
                wbval_next = brev_ea;
                wben_next  = 1'b1;
            end
            else if (is_modify)
            begin
                ea_next    = is_pre ? fixed_val : ptr_val_i;
                wbval_next = fixed_val;
                wben_next  = 1'b1;
            end
            else if (mode_i == mbag_pkg::MODE_OFFSET)
            begin
                ea_next    = fixed_val;
                wben_next  = 1'b0;
            end
            else
            begin
                ea_next    = ptr_val_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            valid_reg <= 1'b0;
            ea_reg    <= 16'h0000;
            brev_reg  <= 1'b0;
            wben_reg  <= 1'b0;
            wbsel_reg <= 4'h0;
            wbval_reg <= 16'h0000;
        end
        else
        begin
            valid_reg <= valid_next;
            ea_reg    <= ea_next;
            brev_reg  <= brev_next;
            wben_reg  <= wben_next;
            wbsel_reg <= wbsel_next;
            wbval_reg <= wbval_next;
        end
    end

    assign ea_valid_o   = valid_reg;
    assign ea_o         = ea_reg;
    assign ea_brev_o    = brev_reg;
    assign ptr_wb_en_o  = wben_reg;
    assign ptr_wb_sel_o = wbsel_reg;
    assign ptr_wb_val_o = wbval_reg;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_mod_upper;
        req_i && mod_hit && !brev_act && (mode_i == mbag_pkg::MODE_POST_INC)
            && (step_val > mend_reg)
        |=> ptr_wb_en_o && (ptr_wb_val_o == 16'($past(step_val) - $past(mod_len)));
    endproperty
    a_mod_upper: assert property (p_mod_upper)
        else $error("Upper overshoot not wrapped by buffer length.");

    property p_mod_lower;
        req_i && mod_hit && !brev_act && (mode_i == mbag_pkg::MODE_PRE_DEC)
            && (step_val < mstart_reg)
        |=> (ea_o == ptr_wb_val_o) && (ea_o == 16'($past(step_val) + $past(mod_len)));
    endproperty
    a_mod_lower: assert property (p_mod_lower)
        else $error("Lower overshoot not wrapped by buffer length.");

    property p_wb_modify;
        req_i && is_modify |=> ea_valid_o && ptr_wb_en_o
            && (ptr_wb_sel_o == $past(ptr_sel_i));
    endproperty
    a_wb_modify: assert property (p_wb_modify)
        else $error("Modify mode did not write the pointer back.");

    property p_offset_keep;
        req_i && (mode_i == mbag_pkg::MODE_OFFSET) |=> ea_valid_o && !ptr_wb_en_o
            && (ea_o == $past(fixed_val));
    endproperty
    a_offset_keep: assert property (p_offset_keep)
        else $error("Offset mode changed the pointer or skipped correction.");

    property p_brev_write_only;
        req_i && (!x_unit_i || !write_i) |=> !ea_brev_o;
    endproperty
    a_brev_write_only: assert property (p_brev_write_only)
        else $error("Bit reversal used outside X unit writes.");

    property p_brev_enable;
        req_i && brev_en && (brev_sel != mbag_pkg::STACK_PTR_SEL) && (ptr_sel_i == brev_sel)
            && is_inc && x_unit_i && write_i && !byte_i
        |=> ea_brev_o && ea_valid_o;
    endproperty
    a_brev_enable: assert property (p_brev_enable)
        else $error("Bit reversal not enabled when all conditions hold.");

    property p_brev_stack;
        req_i && (brev_sel == mbag_pkg::STACK_PTR_SEL) |=> !ea_brev_o;
    endproperty
    a_brev_stack: assert property (p_brev_stack)
        else $error("Bit reversal used with the stack select code.");

    property p_brev_lsb;
        ea_valid_o && ea_brev_o |-> !ea_o[0] && !ptr_wb_val_o[0];
    endproperty
    a_brev_lsb: assert property (p_brev_lsb)
        else $error("Bit-reversed address has LSB set.");

    property p_brev_byte;
        req_i && (byte_i || !is_inc) |=> !ea_brev_o;
    endproperty
    a_brev_byte: assert property (p_brev_byte)
        else $error("Bit reversal used for byte or non-increment access.");

    property p_brev_pre;
        req_i && brev_act && (mode_i == mbag_pkg::MODE_PRE_INC)
        |=> ea_o == {$past(brev_sum), 1'b0};
    endproperty
    a_brev_pre: assert property (p_brev_pre)
        else $error("Bit-reversed address is not pointer plus modifier.");

    property p_brev_priority;
        req_i && brev_act && mod_hit |=> ptr_wb_val_o == $past(brev_ea);
    endproperty
    a_brev_priority: assert property (p_brev_priority)
        else $error("Modulo correction overrode bit reversal.");

    property p_ctrl_write;
        wr_take && (wb_adr_i == mbag_pkg::ADR_BITREV_CTRL) && (wb_sel_i[1:0] == 2'b11)
        |=> ({brev_en, brev_mod} == 16'($past(wb_dat_i)));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Bit reverse control write not applied.");
endmodule : mbag_addr_gen
`default_nettype wire

// [mbag_cpu_model.sv]
// Pointer register file of the instruction execute side facing the address generator.
`timescale 1ns/1ps
`default_nettype none
module mbag_cpu_model
(
    // Clock.
    input  wire logic        clk_i,
    // Pointer read.
    input  wire logic [3:0]  ptr_sel_i,
    output logic      [15:0] ptr_val_o,
    // Pointer write-back.
    input  wire logic        wb_en_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [15:0] wb_val_i
);
    // ==========================================================================
    // Working registers
    // ==========================================================================
    logic [15:0] regs [16];
    assign ptr_val_o = regs[ptr_sel_i];
    always @(posedge clk_i)
    begin
        if (wb_en_i)
            regs[wb_sel_i] <= wb_val_i;
    end
endmodule : mbag_cpu_model
`default_nettype wire

// [test_modulo_bitrev_address_gen.sv]
// Self-checking bench of the modulo and bit-reversed address generator.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_modulo_bitrev_address_gen;
    // ==========================================================================
    // Signals
    // ==========================================================================
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, req = 0;
    logic        byt = 0, wr = 0, xu = 0, ea_v, ea_br, pw_en;
    logic [7:0]  adr = 0;
    logic [31:0] dat = 0, rdat, q;
    logic [2:0]  mode = 0;
    logic [3:0]  psel = 0, pw_sel, sel = 0;
    logic [15:0] pval, off = 0, ea, pw_val, seed = 16'h0054;
    logic [15:0] brev = 0, circ = 0, mstart = 16'h1000, mend = 16'h103F;
    int          n_errors = 0, tests_run = 0;

    mbag_addr_gen i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .req_i(req), .mode_i(mode), .ptr_sel_i(psel), .ptr_val_i(pval),
        .offset_i(off), .byte_i(byt), .write_i(wr), .x_unit_i(xu), .ea_valid_o(ea_v),
        .ea_o(ea), .ea_brev_o(ea_br), .ptr_wb_en_o(pw_en), .ptr_wb_sel_o(pw_sel),
        .ptr_wb_val_o(pw_val));
    mbag_cpu_model i_cpu (.clk_i(clk_i), .ptr_sel_i(psel), .ptr_val_o(pval),
        .wb_en_i(pw_en), .wb_sel_i(pw_sel), .wb_val_i(pw_val));

    initial forever #12.5 clk_i = ~clk_i;

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [15:0] lfsr();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : lfsr

    function automatic logic [14:0] rcadd(input logic [14:0] a, input logic [14:0] b);
        logic [14:0] ra, rb, s, r;
        for (int i = 0; i < 15; i++) begin ra[i] = a[14-i]; rb[i] = b[14-i]; end
        s = ra + rb;
        for (int i = 0; i < 15; i++) r[i] = s[14-i];
        return r;
    endfunction : rcadd

    task automatic expect_ea(input logic [2:0] m, input logic [3:0] s, input logic [15:0] p,
        input logic [15:0] o, input logic b, input logic w, input logic x,
        output logic [15:0] e_ea, output logic [15:0] e_wv, output logic e_en, output logic e_br);
        logic [15:0] q;
        logic        up, inc, post;
        inc  = (m == mbag_pkg::MODE_POST_INC) || (m == mbag_pkg::MODE_PRE_INC);
        post = (m == mbag_pkg::MODE_POST_INC) || (m == mbag_pkg::MODE_POST_DEC);
        up   = inc || (m == mbag_pkg::MODE_OFFSET && !o[15]);
        q    = (m == mbag_pkg::MODE_OFFSET) ? p + o : up ? p + (b ? 16'h0001 : 16'h0002)
             : p - (b ? 16'h0001 : 16'h0002);
        if (circ[15] && s == circ[3:0] && up && q > mend) q = q - (mend - mstart + 16'h0001);
        else if (circ[15] && s == circ[3:0] && !up && q < mstart)
            q = q + (mend - mstart + 16'h0001);
        e_br = brev[15] && circ[11:8] != 4'hF && s == circ[11:8] && inc && x && w && !b;
        e_en = (m != mbag_pkg::MODE_INDIRECT) && (m != mbag_pkg::MODE_OFFSET);
        e_wv = e_br ? {rcadd(p[15:1], brev[14:0]), 1'b0} : q;
        e_ea = (m == mbag_pkg::MODE_INDIRECT) ? p : post ? (e_br ? {p[15:1], 1'b0} : p) : e_wv;
    endtask : expect_ea

    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        sel <= 4'h3;
        adr <= a;
        dat <= {16'h0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic issue(input logic [2:0] m, input logic [3:0] s);
        logic [15:0] r, o, p, e_ea, e_wv;
        logic        e_en, e_br;
        r = lfsr();
        r[1] = r[1] | r[4];
        r[2] = r[2] | r[5];
        o = {{8{r[15]}}, r[14:7]};
        p = i_cpu.regs[s];
        expect_ea(m, s, p, o, r[0], r[1], r[2], e_ea, e_wv, e_en, e_br);
        req  <= 1'b1;
        mode <= m;
        psel <= s;
        off  <= o;
        byt  <= r[0];
        wr   <= r[1];
        xu   <= r[2];
        @(posedge clk_i);
        req <= 1'b0;
        @(posedge clk_i);
        `CHK(ea_v, 1'b1)
        `CHK(ea, e_ea)
        `CHK(ea_br, e_br)
        `CHK(pw_en, e_en)
        if (e_en) `CHK(pw_val, e_wv)
        if (e_en) `CHK(pw_sel, s)
        @(posedge clk_i);
        `CHK(ea_v, 1'b0)
        `CHK(pw_en, 1'b0)
    endtask : issue

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // ==========================================================================
    // Sequence
    // ==========================================================================
    logic [7:0]  adrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
    logic [15:0] rbk  [6] = '{16'hFFFF, 16'h8F0F, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
    logic [15:0] cbr  [3] = '{16'h0000, 16'h8008, 16'h8020};
    logic [15:0] ccc  [3] = '{16'h8005, 16'h8303, 16'h8F0A};

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin bus(1'b0, adrs[i], 16'h0); `CHK(q, 32'h0) end
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, adrs[i], 16'hFFFF);
            bus(1'b0, adrs[i], 16'h0);
            `CHK(q, {16'h0000, rbk[i]})
        end
        $display("test registers done");
        for (int c = 0; c < 3; c++)
        begin
            brev = cbr[c];
            circ = ccc[c];
            // Control writes follow one another with no readback; no request cycle is needed.
            bus(1'b1, 8'h00, brev);
            bus(1'b1, 8'h04, circ);
            bus(1'b1, 8'h08, mstart);
            bus(1'b1, 8'h0C, mend);
            for (int i = 0; i < 16; i++) i_cpu.regs[i] <= lfsr();
            i_cpu.regs[circ[3:0]] <= 16'h1000;
            i_cpu.regs[circ[11:8]] <= 16'h1000;
            @(posedge clk_i);
            for (int i = 0; i < 150; i++)
            begin
                seed = lfsr();
                issue(3'(seed[10:8] % 6), seed[3] ? circ[3:0] : seed[2] ? circ[11:8] : seed[7:4]);
            end
            $display("test address config %0d done", c);
        end
        report_and_stop();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        report_and_stop();
    end
endmodule : test_modulo_bitrev_address_gen
`default_nettype wire
